/* design/tcs_osc_cmp.sv */
`timescale 1ns/1ns
module tcs_osc_cmp
  import tcs_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  // Synchronised edge events and fast mode select
  input  wire logic osc_rise,
  input  wire logic bit_rise,
  input  wire logic frame_rise,
  input  wire logic fast_mode,
  // Result
  output logic      osc_error_ff
);
  logic [OSC_CNT_W-1:0] osc_cnt_ff;
  logic [OSC_CNT_W-1:0] bit_cnt_ff;
  logic [OSC_CNT_W-1:0] bit_scaled;
  logic [3:0]           win_ff;

  // Bit clock at 8192 kHz halves to compare like against like
  assign bit_scaled = fast_mode ? (bit_cnt_ff >> 1) : bit_cnt_ff;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      osc_cnt_ff   <= '0;
      bit_cnt_ff   <= '0;
      win_ff       <= '0;
      osc_error_ff <= 1'b0;
    end else if (frame_rise && win_ff == 4'(OSC_WIN_FRAMES - 1)) begin
      win_ff       <= '0;
      osc_cnt_ff   <= '0;
      bit_cnt_ff   <= '0;
      osc_error_ff <= (osc_cnt_ff > bit_scaled + OSC_CNT_W'(OSC_TOL)) ||
                      (bit_scaled > osc_cnt_ff + OSC_CNT_W'(OSC_TOL)); // R8
    end else begin
      if (frame_rise) win_ff <= win_ff + 4'h1;
      if (osc_rise)   osc_cnt_ff <= osc_cnt_ff + 1'b1;
      if (bit_rise)   bit_cnt_ff <= bit_cnt_ff + 1'b1;
    end
  end
endmodule : tcs_osc_cmp

/* design/tcs_pkg.sv */
package tcs_pkg;
  // ==========================================================
  // Clock and timing
  localparam int unsigned REF_CLK_HZ        = 10000000;
  localparam int unsigned FRAME_HZ          = 8000;
  localparam int unsigned SF_MIN_US         = 250;
  localparam int unsigned SF_MAX_S          = 15;
  localparam int unsigned SF_MAX_FRAMES     = SF_MAX_S * FRAME_HZ;
  localparam int unsigned SF_MIN_FRAMES     = SF_MIN_US * FRAME_HZ / 1000000;
  localparam int unsigned SF_CNT_W          = 17;
  localparam int unsigned OSC_WIN_FRAMES    = 8;
  localparam int unsigned OSC_CNT_W         = 16;
  localparam int unsigned OSC_TOL           = 4;
  localparam int unsigned LANE_OUT_N        = 8;
  localparam int unsigned LANE_IN_N         = 8;
  localparam int unsigned SLOT_W            = 8;
  localparam int unsigned FSYNC_ALT_BITS    = 1;
  // ==========================================================
  // Register map
  localparam logic [3:0]  ADDR_CTRL         = 4'h0;
  localparam logic [3:0]  ADDR_SF_PERIOD    = 4'h1;
  localparam logic [3:0]  ADDR_STATUS       = 4'h2;
  localparam logic [3:0]  ADDR_SYNC_MEM     = 4'h3;
  localparam int unsigned CTRL_SEL_BIT      = 0;
  localparam int unsigned CTRL_DIV2_BIT     = 1;
  localparam int unsigned CTRL_FAST_BIT     = 2;
  localparam logic [16:0] SF_PERIOD_RST     = 17'h00002;
  // ==========================================================
  // Types
  typedef struct packed {
    logic bit_clk;
    logic frame_clk;
  } tcs_clk_pair_t;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [31:0] wdata;
  } tcs_bus_req_t;
endpackage : tcs_pkg

/* design/tcs_sync2.sv */
`timescale 1ns/1ns
module tcs_sync2 #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         sys_rst,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      meta_ff <= '0;
      q       <= '0;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end
endmodule : tcs_sync2

/* design/tcs_top.sv */
// Notes on behaviour
// [R1] Each bit clock runs at 4096 or 8192 kHz with its own 8 kHz frame.
// [R2] Data clock derives from selected bit clock, output at 4096 or 2048 kHz.
// [R3] Output lanes change on the rising edge of the data clock.
// [R4] Input lanes are sampled on the falling edge of the data clock.
// [R5] Component-interface frame sync at 8 kHz follows the selected frame clock.
// [R6] Second 8 kHz frame sync uses the alternative interface timing.
// [R7] Outside drives frame sync input; lanes align to it.
// [R8] Oscillator input is compared to selected bit clock; result on error pin.
// [R9] Superframe pulse period programmable from 250 us to 15 s.
// [R10] Programmable sync pin follows a per-slot sync bit in connection memory.
// [R11] Lanes 8 and 9 go straight to the two HDLC groups.
// [R12] Low disable input floats all eight output lanes.
// [R13] Disable input is tied high when unused.
// [R14] Master clock comes from outside at 66, 50 or 33 MHz; the package sets REF_CLK_HZ to 10 MHz instead.
// [R15] A control bit chooses the first or second clock pair.
`timescale 1ns/1ns
module tcs_top
  import tcs_pkg::*;
(
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  sys_rst,
  // Register port
  input  wire tcs_pkg::tcs_bus_req_t bus_req,
  output logic [31:0]                bus_rdata_ff,
  // Clock pairs and oscillator
  input  wire tcs_pkg::tcs_clk_pair_t clk_pair_first,
  input  wire tcs_pkg::tcs_clk_pair_t clk_pair_second,
  input  wire logic                  osc_compare_in,
  input  wire logic                  tdm_frame_sync_in,
  // Lanes
  input  wire logic [7:0]            tdm_lane_in,
  input  wire logic                  direct_hdlc_lane_first,
  input  wire logic                  direct_hdlc_lane_second,
  input  wire logic [7:0]            lane_tx_data,
  input  wire logic                  tdm_out_disable_n,
  output logic [7:0]                 tdm_lane_out_ff,
  output logic [7:0]                 tdm_lane_oe_ff,
  output logic [7:0]                 lane_rx_data_ff,
  output logic                       hdlc_first_bit_ff,
  output logic                       hdlc_second_bit_ff,
  output logic [7:0]                 slot_index_ff,
  // Clock and sync outputs
  output logic                       tdm_data_clk_out_ff,
  output logic                       component_if_frame_sync_ff,
  output logic                       alt_if_frame_sync_n_ff,
  output logic                       superframe_sync_out_ff,
  output logic                       prog_sync_out_ff,
  output logic                       osc_error_out_ff
);
  // ==========================================================
  // Synchronisers
  logic [7:0] pin_s;
  logic [9:0] lane_s;
  logic       dis_n_s;
  tcs_sync2 #(.W(8)) u_sync_clk (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .d       ({clk_pair_first.bit_clk, clk_pair_first.frame_clk, clk_pair_second.bit_clk,
                clk_pair_second.frame_clk, osc_compare_in, tdm_frame_sync_in, 2'b00}),
    .q       (pin_s)
  );
  tcs_sync2 #(.W(11)) u_sync_lane (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .d       ({tdm_out_disable_n, direct_hdlc_lane_second, direct_hdlc_lane_first, tdm_lane_in}),
    .q       ({dis_n_s, lane_s})
  );

  // ==========================================================
  // Registers
  logic        sel_ff;
  logic        div2_ff;
  logic        fast_ff;
  logic [16:0] sf_period_ff;
  logic [255:0] sync_mem_ff;
  logic        osc_err;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sel_ff       <= 1'b0;
      div2_ff      <= 1'b0;
      fast_ff      <= 1'b0;
      sf_period_ff <= SF_PERIOD_RST;
    end else if (bus_req.wr) begin
      if (bus_req.addr == ADDR_CTRL) begin
        sel_ff  <= bus_req.wdata[CTRL_SEL_BIT]; // R15
        div2_ff <= bus_req.wdata[CTRL_DIV2_BIT];
        fast_ff <= bus_req.wdata[CTRL_FAST_BIT];
      end
      // Clamp keeps the period inside 250 us .. 15 s
      if (bus_req.addr == ADDR_SF_PERIOD) begin
        if (bus_req.wdata[16:0] < 17'(SF_MIN_FRAMES))
          sf_period_ff <= 17'(SF_MIN_FRAMES); // R9
        else if (bus_req.wdata[31:17] != '0 || bus_req.wdata[16:0] > 17'(SF_MAX_FRAMES))
          sf_period_ff <= 17'(SF_MAX_FRAMES); // R9
        else
          sf_period_ff <= bus_req.wdata[16:0];
      end
    end
  end
  // Sync memory: address bit field {slot} carried in wdata[15:8], bit in wdata[0]
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sync_mem_ff <= '0;
    end else if (bus_req.wr && bus_req.addr == ADDR_SYNC_MEM) begin
      sync_mem_ff[bus_req.wdata[15:8]] <= bus_req.wdata[0]; // R10
    end
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      bus_rdata_ff <= '0;
    end else if (bus_req.rd) begin
      unique case (bus_req.addr)
        ADDR_CTRL:      bus_rdata_ff <= {29'h0, fast_ff, div2_ff, sel_ff};
        ADDR_SF_PERIOD: bus_rdata_ff <= {15'h0, sf_period_ff};
        ADDR_STATUS:    bus_rdata_ff <= {30'h0, osc_err, sel_ff};
        default:        bus_rdata_ff <= '0;
      endcase
    end else begin
      bus_rdata_ff <= '0;
    end
  end

  // ==========================================================
  // Clock selection and edge detection
  logic bit_sel;
  logic frame_sel;
  logic bit_d_ff;
  logic frame_d_ff;
  logic fs_d_ff;
  logic osc_d_ff;
  logic bit_rise;
  logic bit_fall;
  logic frame_rise;
  logic fs_rise;
  assign bit_sel    = sel_ff ? pin_s[5] : pin_s[7]; // R15
  assign frame_sel  = sel_ff ? pin_s[4] : pin_s[6]; // R15
  assign bit_rise   = bit_sel && !bit_d_ff;
  assign frame_rise = frame_sel && !frame_d_ff;
  assign bit_fall   = !bit_sel && bit_d_ff;
  assign fs_rise    = pin_s[2] && !fs_d_ff; // R7
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      bit_d_ff   <= 1'b0;
      frame_d_ff <= 1'b0;
      fs_d_ff    <= 1'b0;
      osc_d_ff   <= 1'b0;
    end else begin
      bit_d_ff   <= bit_sel;
      frame_d_ff <= frame_sel;
      fs_d_ff    <= pin_s[2];
      osc_d_ff   <= pin_s[3];
    end
  end

  // ==========================================================
  // Data clock divider
  // Ratio one follows the bit clock; else bit-clock rises divide by two or four
  logic [1:0] div_cnt_ff;
  logic [1:0] div_top;
  logic       tdm_data_clk_out_rise;
  logic       tdm_data_clk_out_fall;
  assign div_top   = {fast_ff & div2_ff, fast_ff | div2_ff};
  // Frame sync restarts the cycle, so the frame's first bit still launches data
  assign tdm_data_clk_out_rise = bit_rise && (fs_rise || div_cnt_ff == 2'h0);
  assign tdm_data_clk_out_fall = !fs_rise && ((div_top == 2'h0) ? bit_fall :
                     (bit_rise && div_cnt_ff == (div_top >> 1) + 2'h1));
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      div_cnt_ff          <= '0;
      tdm_data_clk_out_ff <= 1'b0;
    end else begin
      if (fs_rise) div_cnt_ff <= (bit_rise && div_top != 2'h0) ? 2'h1 : 2'h0; // R7
      else if (bit_rise) div_cnt_ff <= (div_cnt_ff == div_top) ? 2'h0 : div_cnt_ff + 2'h1;
      if (tdm_data_clk_out_rise) tdm_data_clk_out_ff <= 1'b1; // R2
      else if (tdm_data_clk_out_fall || fs_rise) tdm_data_clk_out_ff <= 1'b0; // R2
    end
  end

  // ==========================================================
  // Lanes and slot counter
  logic [2:0] bit_idx_ff;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      bit_idx_ff    <= '0;
      slot_index_ff <= '0;
    end else if (fs_rise) begin
      bit_idx_ff    <= '0; // R7
      slot_index_ff <= '0;
    end else if (tdm_data_clk_out_fall) begin
      bit_idx_ff <= bit_idx_ff + 3'h1;
      if (bit_idx_ff == 3'h7) slot_index_ff <= slot_index_ff + 8'h01;
    end
  end
  genvar g;
  generate
    for (g = 0; g < LANE_OUT_N; g++) begin : g_lane
      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          tdm_lane_out_ff[g] <= 1'b1;
          tdm_lane_oe_ff[g]  <= 1'b0;
          lane_rx_data_ff[g] <= 1'b0;
        end else begin
          tdm_lane_oe_ff[g] <= dis_n_s; // R12
          if (tdm_data_clk_out_rise) tdm_lane_out_ff[g] <= lane_tx_data[g]; // R3
          if (tdm_data_clk_out_fall) lane_rx_data_ff[g] <= lane_s[g]; // R4
        end
      end
    end
  endgenerate
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      hdlc_first_bit_ff  <= 1'b0;
      hdlc_second_bit_ff <= 1'b0;
    end else if (tdm_data_clk_out_fall) begin
      hdlc_first_bit_ff  <= lane_s[8]; // R11
      hdlc_second_bit_ff <= lane_s[9]; // R11
    end
  end

  // ==========================================================
  // Frame syncs, superframe and programmable sync
  logic [16:0] sf_cnt_ff;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      component_if_frame_sync_ff <= 1'b0;
      alt_if_frame_sync_n_ff     <= 1'b1;
      sf_cnt_ff                  <= '0;
      superframe_sync_out_ff     <= 1'b0;
      prog_sync_out_ff           <= 1'b0;
    end else begin
      component_if_frame_sync_ff <= frame_sel; // R5
      // Alternative style: active low, one bit clock wide at frame start
      if (frame_rise) alt_if_frame_sync_n_ff <= 1'b0; // R6
      else if (bit_rise) alt_if_frame_sync_n_ff <= 1'b1; // R6
      superframe_sync_out_ff <= 1'b0;
      if (frame_rise) begin
        if (sf_cnt_ff >= sf_period_ff - 17'h00001) begin
          sf_cnt_ff              <= '0;
          superframe_sync_out_ff <= 1'b1; // R9
        end else begin
          sf_cnt_ff <= sf_cnt_ff + 17'h00001;
        end
      end
      prog_sync_out_ff <= sync_mem_ff[slot_index_ff]; // R10
    end
  end

  tcs_osc_cmp u_osc (
    .ref_clk      (ref_clk),
    .sys_rst      (sys_rst),
    .osc_rise     (pin_s[3] && !osc_d_ff),
    .bit_rise     (bit_rise),
    .frame_rise   (frame_rise),
    .fast_mode    (fast_ff),
    .osc_error_ff (osc_err)
  );
  always_ff @(posedge ref_clk) begin
    if (sys_rst) osc_error_out_ff <= 1'b0;
    else osc_error_out_ff <= osc_err; // R8
  end

  // ==========================================================
  // Assertions
  a_lane_oe_follows: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ##1 tdm_lane_oe_ff == {8{$past(dis_n_s)}}) else $error("lane enable wrong"); // R12
  a_tx_on_rise: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $changed(tdm_lane_out_ff) |-> $past(tdm_data_clk_out_rise)) else $error("tx change off edge"); // R3
  a_rx_on_fall: assert property (@(posedge ref_clk) disable iff (sys_rst)
    tdm_data_clk_out_fall |=> lane_rx_data_ff == $past(lane_s[7:0])) else $error("rx sample wrong"); // R4
  a_sf_pulse_one: assert property (@(posedge ref_clk) disable iff (sys_rst)
    superframe_sync_out_ff |=> !superframe_sync_out_ff) else $error("sf pulse long"); // R9
  a_sf_period_range: assert property (@(posedge ref_clk) disable iff (sys_rst)
    sf_period_ff >= 17'(SF_MIN_FRAMES) && sf_period_ff <= 17'(SF_MAX_FRAMES))
    else $error("sf period range"); // R9
  a_tdm_data_clk_out_rise_sync: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $rose(tdm_data_clk_out_ff) |-> $past(bit_rise)) else $error("tdm_data_clk_out not from bit clk"); // R2
  a_fs_align: assert property (@(posedge ref_clk) disable iff (sys_rst)
    fs_rise |=> bit_idx_ff == 3'h0 && tdm_data_clk_out_ff == $past(bit_rise)) else $error("fs align"); // R7
  a_gci_follow: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ##1 component_if_frame_sync_ff == $past(frame_sel)) else $error("gci sync"); // R5
  a_hdlc_direct: assert property (@(posedge ref_clk) disable iff (sys_rst)
    tdm_data_clk_out_fall |=> hdlc_first_bit_ff == $past(lane_s[8])) else $error("hdlc lane"); // R11
  c_sf_pulse: cover property (@(posedge ref_clk) superframe_sync_out_ff);
  c_osc_err: cover property (@(posedge ref_clk) osc_error_out_ff);
  a_alt_sync_low: assert property (@(posedge ref_clk) disable iff (sys_rst) // R6
    frame_rise |=> !alt_if_frame_sync_n_ff) else $error("alt sync not low");
  a_prog_sync_map: assert property (@(posedge ref_clk) disable iff (sys_rst) // R10
    ##1 prog_sync_out_ff == $past(sync_mem_ff[slot_index_ff])) else $error("prog sync wrong");
  c_dis_low: cover property (@(posedge ref_clk) !tdm_lane_oe_ff[0]);
  c_tdm_data_clk_out_div4: cover property (@(posedge ref_clk) tdm_data_clk_out_rise && div_top == 2'h3);
  c_prog_sync: cover property (@(posedge ref_clk) prog_sync_out_ff);
endmodule : tcs_top

/* verif/tcs_line_model.sv */
`timescale 1ns/1ns
module tcs_line_model #(
  parameter int unsigned BIT_NS     = 800,
  parameter int unsigned FRAME_BITS = 16
) (
  // Controls
  input  wire logic               run_second,
  input  wire logic               osc_slow,
  // Pins
  output tcs_pkg::tcs_clk_pair_t  pair_first,
  output tcs_pkg::tcs_clk_pair_t  pair_second,
  output logic                    frame_sync,
  output logic                    osc
);
  import tcs_pkg::*;
  int unsigned bit_cnt;
  // ==========================================================
  // Line clocks, scaled down so the sampler can follow them
  initial begin
    pair_first  = '0;
    pair_second = '0;
    frame_sync  = 1'b0;
    osc         = 1'b0;
    bit_cnt     = 0;
    #130;
    forever begin
      pair_first.frame_clk  = (bit_cnt == 0);
      pair_second.frame_clk = run_second && (bit_cnt == 0);
      frame_sync            = (bit_cnt == 0);
      pair_first.bit_clk    = 1'b1;
      // Stopped pair stands still, as an unplugged card would
      pair_second.bit_clk   = run_second;
      osc                   = !osc_slow || bit_cnt[0];
      #(BIT_NS / 2);
      pair_first.bit_clk    = 1'b0;
      pair_second.bit_clk   = 1'b0;
      osc                   = 1'b0;
      #(BIT_NS / 2);
      bit_cnt               = (bit_cnt + 1) % FRAME_BITS;
    end
  end
endmodule : tcs_line_model

/* verif/tdm_clock_sync_port_tb_top.sv */
`timescale 1ns/1ns
module tdm_clock_sync_port_tb_top;
  import tcs_pkg::*;
  // ==========================================================
  // Signals
  localparam int unsigned BIT_CYC   = 8;
  localparam int unsigned FRAME_CYC = 128;
  logic          ref_clk    = 1'b0;
  logic          sys_rst    = 1'b1;
  tcs_bus_req_t  bus_req    = '0;
  logic [7:0]    lane_in    = 8'h00;
  logic [7:0]    lane_tx    = 8'h00;
  logic          dir_first  = 1'b0;
  logic          dir_second = 1'b0;
  logic          dis_n      = 1'b1;
  logic          run_second = 1'b0;
  logic          osc_slow   = 1'b0;
  tcs_clk_pair_t pair_first;
  tcs_clk_pair_t pair_second;
  logic          fs;
  logic          osc;
  logic [31:0]   bus_rdata_ff;
  logic [31:0]   rdata;
  logic [7:0]    lane_out;
  logic [7:0]    lane_oe;
  logic [7:0]    lane_rx;
  logic [7:0]    slot;
  logic          hdlc1;
  logic          hdlc2;
  logic          tdm_data_clk_out;
  logic          fsync;
  logic          alt_n;
  logic          superframe_sync_out;
  logic          psync;
  logic          osc_err;
  int unsigned   mismatches  = 0;
  int unsigned   comparisons = 0;
  int unsigned   frame_rises = 0;
  int unsigned   alt_falls   = 0;
  always #50 ref_clk = ~ref_clk;
  always @(posedge fsync) frame_rises++;
  always @(negedge alt_n) alt_falls++;
  tcs_line_model far (.run_second(run_second), .osc_slow(osc_slow), .pair_first(pair_first),
    .pair_second(pair_second), .frame_sync(fs), .osc(osc));
  tcs_top dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .bus_req(bus_req), .bus_rdata_ff(bus_rdata_ff),
    .clk_pair_first(pair_first), .clk_pair_second(pair_second), .osc_compare_in(osc),
    .tdm_frame_sync_in(fs), .tdm_lane_in(lane_in), .direct_hdlc_lane_first(dir_first),
    .direct_hdlc_lane_second(dir_second), .lane_tx_data(lane_tx), .tdm_out_disable_n(dis_n),
    .tdm_lane_out_ff(lane_out), .tdm_lane_oe_ff(lane_oe), .lane_rx_data_ff(lane_rx),
    .hdlc_first_bit_ff(hdlc1), .hdlc_second_bit_ff(hdlc2), .slot_index_ff(slot),
    .tdm_data_clk_out_ff(tdm_data_clk_out), .component_if_frame_sync_ff(fsync), .alt_if_frame_sync_n_ff(alt_n),
    .superframe_sync_out_ff(superframe_sync_out), .prog_sync_out_ff(psync), .osc_error_out_ff(osc_err));
  // ==========================================================
  // Tasks
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    bus_req <= '0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge ref_clk);
    bus_req <= '0;
    @(posedge ref_clk);
    rdata = bus_rdata_ff;
  endtask : rd
  // Rising-edge spacing, in clock cycles, of the data clock or the superframe pin
  task automatic period(input string name, input bit sf, input logic [31:0] exp);
    time t0;
    if (sf) @(posedge superframe_sync_out); else @(posedge tdm_data_clk_out);
    t0 = $time;
    if (sf) @(posedge superframe_sync_out); else @(posedge tdm_data_clk_out);
    check(name, exp, 32'(($time - t0) / 100));
  endtask : period
  // With align set, window starts mid-frame so no edge sits on its boundary
  task automatic frames(input bit align, input logic [31:0] exp);
    int unsigned f0;
    int unsigned a0;
    if (align) @(posedge fsync);
    repeat (FRAME_CYC / 2) @(posedge ref_clk);
    f0 = frame_rises;
    a0 = alt_falls;
    repeat (3 * FRAME_CYC) @(posedge ref_clk);
    check("frame_sync", exp, 32'(frame_rises - f0));
    check("alt_sync", exp, 32'(alt_falls - a0));
  endtask : frames
  task automatic tally_and_finish;
    if (mismatches == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #3000000;
    mismatches++;
    tally_and_finish();
  end
  // ==========================================================
  // Tests
  initial begin
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    check("rst_alt", 32'h1, {31'h0, alt_n});
    check("rst_lane", 32'hFF, {24'h0, lane_out});
    check("rst_oe", 32'h0, {24'h0, lane_oe});
    rd(ADDR_STATUS);
    check("status", 32'h0, rdata);
    rd(ADDR_SF_PERIOD);
    check("sf_rst", 32'(SF_PERIOD_RST), rdata);
    wr(4'hF, 32'hFFFFFFFF);
    rd(4'hF);
    check("unmapped", 32'h0, rdata);
    wr(ADDR_SF_PERIOD, 32'h1);
    rd(ADDR_SF_PERIOD);
    check("sf_clamp", 32'h2, rdata);
    rd(ADDR_SYNC_MEM);
    check("sync_mem", 32'h0, rdata);
    lane_tx    <= 8'h5A;
    lane_in    <= 8'hC3;
    dir_first  <= 1'b1;
    repeat (6 * BIT_CYC) @(posedge ref_clk);
    check("lane_out", 32'h5A, {24'h0, lane_out});
    check("lane_oe", 32'hFF, {24'h0, lane_oe});
    check("lane_rx", 32'hC3, {24'h0, lane_rx});
    check("hdlc_pair", 32'h2, {30'h0, hdlc1, hdlc2});
    dis_n      <= 1'b0;
    dir_first  <= 1'b0;
    dir_second <= 1'b1;
    repeat (6 * BIT_CYC) @(posedge ref_clk);
    check("lane_off", 32'h0, {24'h0, lane_oe});
    check("hdlc_pair", 32'h1, {30'h0, hdlc1, hdlc2});
    dis_n      <= 1'b1;
    frames(1'b1, 32'h3);
    // Every data clock mode: div2 on bit1, 8192 kHz input on bit2
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_CTRL, 32'(m) << 1);
      repeat (4 * FRAME_CYC) @(posedge ref_clk);
      period("data_clk", 1'b0, 32'(BIT_CYC << (m % 2 + m / 2)));
    end
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_SF_PERIOD, 32'h3);
    rd(ADDR_SF_PERIOD);
    check("sf_period", 32'h3, rdata);
    period("superframe", 1'b1, 32'(3 * FRAME_CYC));
    // A model frame holds only two slots
    wr(ADDR_SYNC_MEM, 32'h00000101);
    wait (slot === 8'h00);
    wait (slot === 8'h01);
    repeat (3) @(posedge ref_clk);
    check("prog_sync_set", 32'h1, {31'h0, psync});
    wait (slot === 8'h00);
    repeat (3) @(posedge ref_clk);
    check("prog_sync_clr", 32'h0, {31'h0, psync});
    repeat (24 * FRAME_CYC) @(posedge ref_clk);
    check("osc_ok", 32'h0, {31'h0, osc_err});
    osc_slow   <= 1'b1;
    repeat (24 * FRAME_CYC) @(posedge ref_clk);
    check("osc_bad", 32'h1, {31'h0, osc_err});
    rd(ADDR_STATUS);
    check("status_err", 32'h2, rdata);
    osc_slow   <= 1'b0;
    wr(ADDR_CTRL, 32'h1);
    rd(ADDR_STATUS);
    check("status_sel", 32'h1, {31'h0, rdata[0]});
    frames(1'b0, 32'h0);
    run_second <= 1'b1;
    frames(1'b1, 32'h3);
    tally_and_finish();
  end
endmodule : tdm_clock_sync_port_tb_top
